// >>> design/cdh_card.sv
`timescale 1ns/10ps
`include "cdh_cfg.svh"
module cdh_card
    import cdh_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               rst_b_i,
    // User side: words to send on host reads
    input  wire logic [`CDH_DW-1:0] tx_data_i,
    input  wire logic               tx_valid_i,
    output logic                    tx_ready_o,
    // User side: words received on host writes
    output logic [`CDH_DW-1:0]      rx_data_o,
    output logic                    rx_valid_o,
    input  wire logic               rx_ready_i,
    output logic                    rx_last_o,
    // Link
    cdh_if.card                     bus
);
    logic [3:0]         s1_q, s2_q, s3_q;
    logic               req_q;
    logic [2:0]         gap_q;
    logic               oe_q;
    logic [`CDH_DW-1:0] do_q;
    logic [`CDH_DW-1:0] rxd_q;
    logic               rxv_q, rxl_q;
    logic               ack_fall_w, ack_rise_w, wr_rise_w, want_w;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers, third stage for edges
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
            s3_q <= 4'hf;
        end else begin
            s1_q <= {bus.dma_acknowledge_n, bus.io_read_strobe_n,
                     bus.io_write_strobe_n, ~bus.terminal_count};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign ack_fall_w = !s2_q[3] && s3_q[3];
    assign ack_rise_w = s2_q[3] && !s3_q[3];
    assign wr_rise_w  = s2_q[1] && !s3_q[1];
    assign want_w     = rx_valid_o ? 1'b0 : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Request: raised when a word can move, held until acknowledge
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_q <= 1'b0;
            gap_q <= 3'h0;
        end else begin
            if (ack_rise_w) begin
                gap_q <= 3'(`CDH_GAP_CYC + 2);
            end else if (gap_q != 3'h0) begin
                gap_q <= gap_q - 3'h1;
            end
            if (ack_fall_w) begin
                req_q <= 1'b0;
            end else if (!req_q && gap_q == 3'h0 && s2_q[3] && !ack_rise_w) begin
                req_q <= bus.latched_read_not_write ? tx_valid_i : want_w;
            end
        end
    end
    assign bus.dma_request = req_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read data drive, only while acknowledge and read strobe low
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oe_q <= 1'b0;
            do_q <= '0;
        end else begin
            oe_q <= !s2_q[3] && !s2_q[2] && bus.latched_read_not_write;
            if (ack_fall_w) begin
                do_q <= tx_data_i;
            end
        end
    end
    assign tx_ready_o        = ack_fall_w && bus.latched_read_not_write;
    assign bus.card_data_out = do_q;
    assign bus.card_data_oe  = oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Write capture into holding register
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rxd_q <= '0;
            rxv_q <= 1'b0;
            rxl_q <= 1'b0;
        end else if (wr_rise_w && !s2_q[3]) begin
            rxd_q <= bus.data_bus;
            rxv_q <= 1'b1;
            rxl_q <= !s2_q[0];
        end else if (rx_ready_i) begin
            rxv_q <= 1'b0;
        end
    end
    assign rx_data_o  = rxd_q;
    assign rx_valid_o = rxv_q;
    assign rx_last_o  = rxl_q;
endmodule

// >>> design/cdh_cfg.svh
`ifndef CDH_CFG_SVH
`define CDH_CFG_SVH

// Core clock period in ns (100 MHz)
`define CDH_CLK_PERIOD_NS   10
// Host bus clock period in ps (62.5 ns); the divider makes 60 ns from core clock (CDH_HBC_HALF)
`define CDH_HBC_PERIOD_PS   62500
`define CDH_HBC_HALF        3
// Acknowledge widths per cycle type, ns
`define CDH_ACK_A_NS        427
`define CDH_ACK_B_NS        302
`define CDH_ACK_C_NS        175
`define CDH_ACK_D_NS        115
// Acknowledge low to strobe low lead, ns
`define CDH_LEAD_AB_NS      80
`define CDH_LEAD_CD_NS      15
// Strobe high to acknowledge high gap, ns
`define CDH_TAIL_A_NS       80
`define CDH_TAIL_BCD_NS     15
// Read/write indicator margin, ns
`define CDH_RW_MARGIN_NS    10
// Request removal before acknowledge high, ns
`define CDH_REQ_DROP_NS     15
// Re-request gap after acknowledge high, ns
`define CDH_REQ_GAP_NS      40
// Cycle counts: minimums round up
`define CDH_CEIL(ns)        (((ns) + `CDH_CLK_PERIOD_NS - 1) / `CDH_CLK_PERIOD_NS)
`define CDH_RW_CYC          `CDH_CEIL(`CDH_RW_MARGIN_NS)
`define CDH_DROP_CYC        `CDH_CEIL(`CDH_REQ_DROP_NS)
`define CDH_GAP_CYC         `CDH_CEIL(`CDH_REQ_GAP_NS)
// Data width
`define CDH_DW              16

`endif

// >>> design/cdh_host.sv
`timescale 1ns/10ps
`include "cdh_cfg.svh"
// Operation
// - Four cycle types with minimum acknowledge widths
// - Acknowledge falls on host clock falling edge
// - Strobe rises before acknowledge, 80/15 ns
// - Terminal count spans final cycle acknowledge
// - Read/write indicator settles around acknowledge
// - Card may not hold request across cycles
// - Card holds request until acknowledge low
// - Card drops request 15 ns before release
// - Card waits 40 ns before re-request
// - Card buffers follow indicator and strobes
// - Card synchronises on own clock
// - Request high; acknowledge, strobes low active
// - Indicator high read, low write; width ignored
module cdh_host
    import cdh_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               rst_b_i,
    // User side: cycle setup
    input  wire cdh_ctype_t         ctype_i,
    input  wire logic               read_i,
    input  wire logic               last_i,
    // User side: write data in
    input  wire logic [`CDH_DW-1:0] wr_data_i,
    input  wire logic               wr_valid_i,
    output logic                    wr_ready_o,
    // User side: read data out
    output logic [`CDH_DW-1:0]      rd_data_o,
    output logic                    rd_valid_o,
    input  wire logic               rd_ready_i,
    output logic                    busy_o,
    // Link
    cdh_if.host                     bus
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LEAD, S_STROBE, S_TAIL, S_HOLD} cdh_st_t;

    localparam int ACK_A = `CDH_CEIL(`CDH_ACK_A_NS);
    localparam int ACK_B = `CDH_CEIL(`CDH_ACK_B_NS);
    localparam int ACK_C = `CDH_CEIL(`CDH_ACK_C_NS);
    localparam int ACK_D = `CDH_CEIL(`CDH_ACK_D_NS);
    localparam int LEAD_AB = `CDH_CEIL(`CDH_LEAD_AB_NS);
    localparam int LEAD_CD = `CDH_CEIL(`CDH_LEAD_CD_NS);
    localparam int TAIL_A = `CDH_CEIL(`CDH_TAIL_A_NS);
    localparam int TAIL_BCD = `CDH_CEIL(`CDH_TAIL_BCD_NS);

    cdh_st_t          st_q;
    logic [2:0]       div_q;
    logic             hclk_q;
    logic             req_s1_q, req_s2_q;
    logic [6:0]       cnt_q;
    logic [6:0]       width_q;
    logic [6:0]       lead_q;
    logic [6:0]       tail_q;
    logic             rd_q;
    logic             last_q;
    logic [`CDH_DW-1:0] buf_q [2];
    logic [1:0]       bcnt_q;
    logic             bwr_q;
    logic             fall_w;
    logic             ack_n_q, rs_n_q, ws_n_q, tc_q, rnw_q, hoe_q;
    logic [`CDH_DW-1:0] hdo_q;
    logic             take_w, push_w, pop_w;
    logic             busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // Host bus clock divider
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q  <= 3'h0;
            hclk_q <= 1'b1;
        end else if (div_q == 3'(`CDH_HBC_HALF - 1)) begin
            div_q  <= 3'h0;
            hclk_q <= ~hclk_q;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end
    assign fall_w = hclk_q && (div_q == 3'(`CDH_HBC_HALF - 1));

    // Request synchroniser
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= bus.dma_request;
            req_s2_q <= req_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer: write data toward card, read data toward user
    assign take_w = (st_q == S_IDLE) && req_s2_q && fall_w
                    && (read_i ? (bcnt_q != 2'h2) : (bcnt_q != 2'h0));
    assign push_w = read_i ? 1'b0 : (wr_valid_i && wr_ready_o);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bcnt_q  <= 2'h0;
            bwr_q   <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            // Shift first, so a word entering in the same cycle is not lost
            if (pop_w) begin
                buf_q[0] <= buf_q[1];
            end
            // Read sample enters at strobe release
            if (st_q == S_STROBE && cnt_q == 7'h0 && rd_q) begin
                buf_q[bcnt_q[0] ^ pop_w] <= bus.data_bus;
            end else if (push_w) begin
                buf_q[bcnt_q[0] ^ pop_w] <= wr_data_i;
            end
            bcnt_q <= bcnt_q + 2'(((st_q == S_STROBE && cnt_q == 7'h0 && rd_q) || push_w) ? 1 : 0)
                             - 2'(pop_w ? 1 : 0);
            bwr_q  <= ~read_i;
        end
    end
    assign pop_w = rd_valid_o ? (rd_ready_i && bwr_q == 1'b0 && bcnt_q != 2'h0)
                              : (st_q == S_TAIL && cnt_q == 7'h0 && !rd_q);
    assign rd_data_o  = buf_q[0];
    assign rd_valid_o = !bwr_q && bcnt_q != 2'h0;
    assign wr_ready_o = !read_i && bcnt_q != 2'h2 && st_q == S_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencer
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q    <= S_IDLE;
            cnt_q   <= 7'h0;
            width_q <= 7'h0;
            lead_q  <= 7'h0;
            tail_q  <= 7'h0;
            rd_q    <= 1'b1;
            last_q  <= 1'b0;
        end else begin
            unique case (st_q)
                S_IDLE: begin
                    if (take_w) begin
                        unique case (ctype_i)
                            CDH_TYPE_A: begin width_q <= 7'(ACK_A); lead_q <= 7'(LEAD_AB);
                                tail_q <= 7'(TAIL_A); end
                            CDH_TYPE_B: begin width_q <= 7'(ACK_B); lead_q <= 7'(LEAD_AB);
                                tail_q <= 7'(TAIL_BCD); end
                            CDH_TYPE_C: begin width_q <= 7'(ACK_C); lead_q <= 7'(LEAD_CD);
                                tail_q <= 7'(TAIL_BCD); end
                            CDH_TYPE_D: begin width_q <= 7'(ACK_D); lead_q <= 7'(LEAD_CD);
                                tail_q <= 7'(TAIL_BCD); end
                        endcase
                        rd_q   <= read_i;
                        last_q <= last_i;
                        cnt_q  <= 7'(`CDH_RW_CYC - 1);
                        st_q   <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_q == 7'h0 && fall_w) begin
                        cnt_q <= lead_q - 7'h1;
                        st_q  <= S_LEAD;
                    end else if (cnt_q != 7'h0) begin
                        cnt_q <= cnt_q - 7'h1;
                    end
                end
                S_LEAD: begin
                    if (cnt_q == 7'h0) begin
                        cnt_q <= width_q - lead_q - tail_q - 7'h1;
                        st_q  <= S_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 7'h1;
                    end
                end
                S_STROBE: begin
                    if (cnt_q == 7'h0) begin
                        cnt_q <= tail_q - 7'h1;
                        st_q  <= S_TAIL;
                    end else begin
                        cnt_q <= cnt_q - 7'h1;
                    end
                end
                S_TAIL: begin
                    if (cnt_q == 7'h0) begin
                        cnt_q <= 7'(`CDH_RW_CYC - 1);
                        st_q  <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 7'h1;
                    end
                end
                S_HOLD: begin
                    if (cnt_q == 7'h0) begin
                        st_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 7'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered bus outputs
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_n_q <= 1'b1;
            rs_n_q  <= 1'b1;
            ws_n_q  <= 1'b1;
            tc_q    <= 1'b0;
            rnw_q   <= 1'b1;
            hoe_q   <= 1'b0;
            hdo_q   <= '0;
            busy_q  <= 1'b0;
        end else begin
            ack_n_q <= !(st_q == S_LEAD || st_q == S_STROBE || st_q == S_TAIL
                         || (st_q == S_SETUP && cnt_q == 7'h0 && fall_w));
            rs_n_q  <= !(rd_q && ((st_q == S_LEAD && cnt_q == 7'h0)
                         || (st_q == S_STROBE && cnt_q != 7'h0)));
            ws_n_q  <= !(!rd_q && ((st_q == S_LEAD && cnt_q == 7'h0)
                         || (st_q == S_STROBE && cnt_q != 7'h0)));
            tc_q    <= last_q && (st_q == S_LEAD || st_q == S_STROBE || st_q == S_TAIL
                         || (st_q == S_SETUP && cnt_q == 7'h0 && fall_w));
            // Indicator tracks pending direction while idle, so the card can request
            if (st_q == S_IDLE) begin
                rnw_q <= read_i;
            end
            hoe_q   <= !rd_q && st_q != S_IDLE;
            hdo_q   <= buf_q[0];
            // Busy from the next state of the sequencer
            busy_q  <= take_w || (st_q != S_IDLE && !(st_q == S_HOLD && cnt_q == 7'h0));
        end
    end

    assign bus.dma_acknowledge_n      = ack_n_q;
    assign bus.io_read_strobe_n       = rs_n_q;
    assign bus.io_write_strobe_n      = ws_n_q;
    assign bus.terminal_count         = tc_q;
    assign bus.latched_read_not_write = rnw_q;
    assign bus.byte_width_n           = 1'b1;
    assign bus.host_bus_clock         = hclk_q;
    assign bus.host_data_out          = hdo_q;
    assign bus.host_data_oe           = hoe_q;
    assign busy_o                     = busy_q;
endmodule

// >>> design/cdh_if.sv
`timescale 1ns/10ps
`include "cdh_cfg.svh"
interface cdh_if;
    logic                 dma_request;
    logic                 dma_acknowledge_n;
    logic                 terminal_count;
    logic                 io_read_strobe_n;
    logic                 io_write_strobe_n;
    logic                 latched_read_not_write;
    logic                 byte_width_n;
    logic                 host_bus_clock;
    logic [`CDH_DW-1:0]   host_data_out;
    logic                 host_data_oe;
    logic [`CDH_DW-1:0]   card_data_out;
    logic                 card_data_oe;
    logic [`CDH_DW-1:0]   data_bus;

    // Resolved data bus from the two enables
    assign data_bus = card_data_oe ? card_data_out :
                      host_data_oe ? host_data_out : '0;

    modport host (
        input  dma_request, data_bus,
        output dma_acknowledge_n, terminal_count, io_read_strobe_n, io_write_strobe_n,
               latched_read_not_write, byte_width_n, host_bus_clock,
               host_data_out, host_data_oe
    );
    modport card (
        output dma_request, card_data_out, card_data_oe,
        input  dma_acknowledge_n, terminal_count, io_read_strobe_n, io_write_strobe_n,
               latched_read_not_write, byte_width_n, host_bus_clock, data_bus
    );
endinterface

// >>> design/cdh_pkg.sv
package cdh_pkg;
    typedef enum logic [1:0] {CDH_TYPE_A, CDH_TYPE_B, CDH_TYPE_C, CDH_TYPE_D} cdh_ctype_t;
endpackage

// >>> sim/cdh_chk.sv
`timescale 1ns/10ps
module cdh_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Link signals
    input wire logic dma_request,
    input wire logic dma_acknowledge_n,
    input wire logic terminal_count,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic latched_read_not_write,
    input wire logic byte_width_n,
    input wire logic host_bus_clock,
    input wire logic host_data_oe,
    input wire logic card_data_oe
);
    logic [7:0] ack_cnt_q;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Length of the current acknowledge low phase
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_cnt_q <= 8'h00;
        end else if (!dma_acknowledge_n) begin
            ack_cnt_q <= ack_cnt_q + 8'h01;
        end else begin
            ack_cnt_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Acknowledge, strobes and count
    property p_ack_width;
        $rose(dma_acknowledge_n) |-> ack_cnt_q >= 8'h0c && ack_cnt_q <= 8'h3c;
    endproperty
    a_ack_width: assert property (p_ack_width) else $error("ack width out of range");
    property p_ack_clk;
        $fell(dma_acknowledge_n) |-> !host_bus_clock || !$past(host_bus_clock);
    endproperty
    a_ack_clk: assert property (p_ack_clk) else $error("ack not in clock low phase");
    property p_strb_lead;
        (!io_read_strobe_n || !io_write_strobe_n) |-> !dma_acknowledge_n && !$past(dma_acknowledge_n);
    endproperty
    a_strb_lead: assert property (p_strb_lead) else $error("strobe outside ack");
    property p_strb_tail;
        $rose(dma_acknowledge_n) |-> $past(io_read_strobe_n, 2) && $past(io_write_strobe_n, 2);
    endproperty
    a_strb_tail: assert property (p_strb_tail) else $error("strobe too late");
    property p_tc_in_ack;
        terminal_count |-> !dma_acknowledge_n;
    endproperty
    a_tc_in_ack: assert property (p_tc_in_ack) else $error("count outside ack");
    property p_rw_stable;
        (!dma_acknowledge_n || !$past(dma_acknowledge_n)) |-> $stable(latched_read_not_write);
    endproperty
    a_rw_stable: assert property (p_rw_stable) else $error("direction moved");
    property p_dir_rd;
        !io_read_strobe_n |-> latched_read_not_write && io_write_strobe_n;
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("read strobe in write");
    property p_dir_wr;
        !io_write_strobe_n |-> !latched_read_not_write && byte_width_n;
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("write strobe in read");
    property p_card_oe;
        card_data_oe |-> !dma_acknowledge_n && latched_read_not_write && !host_data_oe;
    endproperty
    a_card_oe: assert property (p_card_oe) else $error("card drives out of read");

    ////////////////////////////////////////////////////////////////////////////////
    // Request handling
    property p_req_hold;
        $fell(dma_request) |-> !dma_acknowledge_n;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_req_drop;
        $rose(dma_acknowledge_n) |-> !$past(dma_request, 2);
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request dropped late");
    property p_req_gap;
        $rose(dma_acknowledge_n) && !dma_request |-> ##1 !dma_request [*4];
    endproperty
    a_req_gap: assert property (p_req_gap) else $error("request back too soon");
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
`include "cdh_cfg.svh"
module tb;
    import cdh_pkg::*;
    logic               core_clk_i;
    logic               rst_b_i;
    cdh_ctype_t         ctype_i;
    logic               read_i;
    logic               last_i;
    logic               wr_valid_i;
    logic               rd_ready_i;
    logic               tx_valid_i;
    logic               rx_ready_i;
    logic [`CDH_DW-1:0] wr_data_i;
    logic [`CDH_DW-1:0] tx_data_i;
    logic [`CDH_DW-1:0] rd_data_o;
    logic [`CDH_DW-1:0] rx_data_o;
    logic               wr_ready_o;
    logic               rd_valid_o;
    logic               busy_o;
    logic               tx_ready_o;
    logic               rx_valid_o;
    logic               rx_last_o;
    logic [`CDH_DW:0]   wq[$];
    logic [`CDH_DW-1:0] rq[$];
    logic [31:0]        rng;
    int                 fails;
    int                 compares;
    int                 ack_len;
    int                 min_cyc[4];

    cdh_if bus_if();
    cdh_host i_cdh_host (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ctype_i(ctype_i),
        .read_i(read_i), .last_i(last_i), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
        .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .busy_o(busy_o), .bus(bus_if));
    cdh_card i_cdh_card (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_last_o(rx_last_o), .bus(bus_if));
    cdh_chk i_cdh_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .dma_request(bus_if.dma_request), .dma_acknowledge_n(bus_if.dma_acknowledge_n),
        .terminal_count(bus_if.terminal_count), .io_read_strobe_n(bus_if.io_read_strobe_n),
        .io_write_strobe_n(bus_if.io_write_strobe_n),
        .latched_read_not_write(bus_if.latched_read_not_write),
        .byte_width_n(bus_if.byte_width_n), .host_bus_clock(bus_if.host_bus_clock),
        .host_data_oe(bus_if.host_data_oe), .card_data_oe(bus_if.card_data_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task complete_run();
        $display("Checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task cmp_word(input string what, input logic [`CDH_DW:0] exp, input logic [`CDH_DW:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cmp_flag(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Handshake on a ready flag, bounded
    task handshake(input bit use_tx);
        int n;
        n = 0;
        while ((use_tx ? tx_ready_o : wr_ready_o) !== 1'b1 && n < 3000) begin
            @(negedge core_clk_i);
            n++;
        end
        @(posedge core_clk_i);
        wr_valid_i <= 1'b0;
        tx_valid_i <= 1'b0;
        @(posedge core_clk_i); // One edge with valid low between words
        if (n >= 3000) begin
            fails++;
            complete_run();
        end
    endtask
    task do_xfer(input cdh_ctype_t ct, input logic rd, input logic lst);
        logic [`CDH_DW-1:0] d;
        d = `CDH_DW'(next_rand());
        ctype_i <= ct;
        read_i <= rd;
        last_i <= lst;
        if (rd) begin
            tx_data_i <= d;
            tx_valid_i <= 1'b1;
            rq.push_back(d);
        end else begin
            wr_data_i <= d;
            wr_valid_i <= 1'b1;
            wq.push_back({lst, d});
        end
        @(negedge core_clk_i);
        handshake(rd);
    endtask
    task wait_idle();
        int n;
        for (n = 0; n < 3000 && (wq.size() > 0 || rq.size() > 0 || busy_o !== 1'b0); n++) begin
            @(posedge core_clk_i);
        end
        if (n >= 3000) begin
            fails++;
            complete_run();
        end else begin
            repeat (8) @(posedge core_clk_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Random receiver stalls on both user sides
    always @(posedge core_clk_i) begin
        rd_ready_i <= next_rand() % 3 == 0;
        rx_ready_i <= next_rand() % 3 == 0;
    end

    // Delivered words against the oldest note
    always @(posedge core_clk_i) begin
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
            cmp_word("rx word", wq.size() ? wq.pop_front() : 'x, {rx_last_o, rx_data_o});
        end
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
            cmp_word("rd word", rq.size() ? {1'b0, rq.pop_front()} : 'x, {1'b0, rd_data_o});
        end
    end

    // Wire watch: direction, count flag, width flag and ack length
    always @(posedge core_clk_i) begin
        if (rst_b_i && bus_if.dma_acknowledge_n === 1'b0) begin
            if (ack_len == 0) begin
                cmp_flag("direction", read_i, bus_if.latched_read_not_write);
                cmp_flag("count", last_i, bus_if.terminal_count);
                cmp_flag("width", 1'b1, bus_if.byte_width_n);
            end
            ack_len++;
        end else if (ack_len != 0) begin
            cmp_flag("ack length", 1'b1, ack_len >= min_cyc[ctype_i]);
            ack_len = 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rng = 32'd60614;
        fails = 0;
        compares = 0;
        ack_len = 0;
        min_cyc = '{`CDH_CEIL(`CDH_ACK_A_NS), `CDH_CEIL(`CDH_ACK_B_NS),
                    `CDH_CEIL(`CDH_ACK_C_NS), `CDH_CEIL(`CDH_ACK_D_NS)};
        rst_b_i = 1'b0;
        ctype_i = CDH_TYPE_A;
        {read_i, last_i, wr_valid_i, tx_valid_i} = 4'h0;
        wr_data_i = 16'h0000;
        tx_data_i = 16'h0000;
        repeat (20) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        for (int t = 0; t < 4; t++) begin
            do_xfer(cdh_ctype_t'(t), 1'b0, t[0]);
            wait_idle();
            do_xfer(cdh_ctype_t'(t), 1'b1, t[1]);
            wait_idle();
        end
        repeat (6) do_xfer(CDH_TYPE_D, 1'b0, 1'b0);
        wait_idle();
        repeat (4) do_xfer(CDH_TYPE_B, 1'b1, 1'b0);
        wait_idle();
        complete_run();
    end
endmodule
